// ===== rtl/etcmp_top.sv
`timescale 1ns/1ps

// Function
// - bit 15 disables channel one, reset enabled
// - bit 15 disables channel two, reset enabled
// - high bits 7-0 hold compare 23-16, ones
// - low register holds compare 15-0, ones
// - high write only stages, nothing active changes
// - low write loads all 24 bits together
// - lone low write uses present high contents
// - compare value is absolute event timer time
// - disable masks interrupt and blocks new status flag sets; a set flag stays set
module etcmp_top (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        spi_sclk,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_mosi,
	output logic             spi_miso_out,
	output logic             spi_miso_oe_n,
	input  wire logic [23:0] timer_value,
	input  wire logic [1:0]  match_clear,
	output logic [1:0]       match_flag,
	output logic [1:0]       match_irq,
	output logic [1:0]       match_off,
	output logic [23:0]      match_time_one,
	output logic [23:0]      match_time_two
);

	// register index: bit 1 is channel, bit 0 is low half
	function automatic logic [2:0] reg_decode(input logic [5:0] addr);
		logic [5:0] rel;
		rel = addr - etcmp_pkg::MATCH_ONE_HIGH_ADDR;
		if (addr >= etcmp_pkg::MATCH_ONE_HIGH_ADDR &&
		    addr <= etcmp_pkg::MATCH_TWO_LOW_ADDR) begin
			reg_decode = {1'b1, rel[1:0]};
		end else begin
			reg_decode = 3'h0;
		end
	endfunction : reg_decode

	logic [2:0]                  sclk_sync_reg;
	logic [1:0]                  cs_sync_reg;
	logic [1:0]                  mosi_sync_reg;
	logic                        sclk_rise;
	logic                        sclk_fall;
	logic                        cs_act;
	etcmp_pkg::etcmp_phase_type  phase_reg;
	logic [4:0]                  bit_cnt_reg;
	logic [15:0]                 shift_reg;
	logic [15:0]                 shift_next;
	logic                        rd_reg;
	logic [5:0]                  addr_reg;
	logic [15:0]                 tx_reg;
	logic                        tx_fresh_reg;
	logic                        word_done;
	logic                        head_done;
	logic [2:0]                  dec;
	etcmp_pkg::etcmp_stage_type  stage_reg [2];
	logic [15:0]                 low_reg [2];
	etcmp_pkg::etcmp_active_type active_reg [2];
	logic [1:0]                  eq_prev_reg;
	logic [1:0]                  eq_now;
	logic [1:0]                  flag_reg;

	// link inputs pass two flip-flops; sclk keeps a third for edges
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg   <= 2'h3;
			mosi_sync_reg <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
			cs_sync_reg   <= {cs_sync_reg[0], spi_cs_n};
			mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
		end
	end

	assign cs_act    = ~cs_sync_reg[1];
	assign sclk_rise = cs_act & sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign sclk_fall = cs_act & ~sclk_sync_reg[1] & sclk_sync_reg[2];
	assign shift_next = {shift_reg[14:0], mosi_sync_reg[1]};
	assign head_done = sclk_rise && phase_reg == etcmp_pkg::ETCMP_HEAD &&
	                   bit_cnt_reg == etcmp_pkg::CNT_HEADER - 5'h01;
	assign word_done = sclk_rise && phase_reg == etcmp_pkg::ETCMP_DATA &&
	                   bit_cnt_reg == etcmp_pkg::CNT_WORD - 5'h01;
	assign dec = reg_decode(addr_reg);

	// serial framing: header byte then 16-bit words, address auto-advances
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !cs_act) begin
			phase_reg   <= etcmp_pkg::ETCMP_HEAD;
			bit_cnt_reg <= 5'h00;
			shift_reg   <= 16'h0000;
			rd_reg      <= 1'b0;
			addr_reg    <= 6'h00;
		end else if (sclk_rise) begin
			shift_reg <= shift_next;
			case (phase_reg)
				etcmp_pkg::ETCMP_HEAD: begin
					if (head_done) begin
						rd_reg      <= shift_next[etcmp_pkg::RD_BIT];
						addr_reg    <= shift_next[5:0];
						phase_reg   <= etcmp_pkg::ETCMP_DATA;
					end
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
				end
				etcmp_pkg::ETCMP_DATA: begin
					if (word_done) begin
						addr_reg    <= addr_reg + 6'h01;
						bit_cnt_reg <= etcmp_pkg::CNT_HEADER;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
					end
				end
				default: begin
					phase_reg <= etcmp_pkg::ETCMP_HEAD;
				end
			endcase
		end
	end

	function automatic logic [15:0] read_word(input logic [2:0] d,
		input etcmp_pkg::etcmp_stage_type st [2],
		input logic [15:0] lo [2]);
		if (!d[2]) begin
			read_word = etcmp_pkg::READ_ZERO;
		end else if (d[0]) begin
			read_word = lo[d[1]];
		end else begin
			read_word = {st[d[1]].off, etcmp_pkg::RSVD_ZERO, st[d[1]].hi};
		end
	endfunction : read_word

	// read data loads at each word boundary and shifts on falling edges
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !cs_act) begin
			tx_reg       <= 16'h0000;
			tx_fresh_reg <= 1'b0;
		end else if (head_done) begin
			tx_reg       <= read_word(reg_decode(shift_next[5:0]),
			                          stage_reg, low_reg);
			tx_fresh_reg <= 1'b1;
		end else if (word_done) begin
			tx_reg       <= read_word(reg_decode(addr_reg + 6'h01),
			                          stage_reg, low_reg);
			tx_fresh_reg <= 1'b1;
		end else if (sclk_fall) begin
			if (tx_fresh_reg) begin
				tx_fresh_reg <= 1'b0;
			end else begin
				tx_reg <= {tx_reg[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			spi_miso_out  <= 1'b0;
			spi_miso_oe_n <= 1'b1;
		end else begin
			spi_miso_out  <= tx_reg[15];
			spi_miso_oe_n <= ~(cs_act && rd_reg &&
			                   phase_reg == etcmp_pkg::ETCMP_DATA);
		end
	end

	// staged and active compare registers per channel
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				stage_reg[ch].off <= etcmp_pkg::OFF_RESET;
				stage_reg[ch].hi  <= etcmp_pkg::HIGH_RESET;
				low_reg[ch]       <= etcmp_pkg::LOW_RESET;
				active_reg[ch]    <= {etcmp_pkg::OFF_RESET,
				                      etcmp_pkg::HIGH_RESET,
				                      etcmp_pkg::LOW_RESET};
			end else if (word_done && !rd_reg && dec[2] &&
			             dec[1] == 1'(ch)) begin
				if (!dec[0]) begin
					// staging only; active state untouched
					stage_reg[ch].off <= shift_next[etcmp_pkg::OFF_BIT];
					stage_reg[ch].hi  <= shift_next[etcmp_pkg::HIGH_MSB:0];
				end else begin
					low_reg[ch] <= shift_next;
					// one parallel load from present high contents
					active_reg[ch] <= {stage_reg[ch].off,
					                   stage_reg[ch].hi, shift_next};
				end
			end
		end

		// absolute time equality against the event timer
		assign eq_now[ch] = ~active_reg[ch].off &&
		                    timer_value == active_reg[ch].value;

		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				eq_prev_reg[ch] <= 1'b0;
				flag_reg[ch]    <= 1'b0;
			end else begin
				eq_prev_reg[ch] <= eq_now[ch];
				// set on first equal cycle, set wins over clear
				if (eq_now[ch] && !eq_prev_reg[ch]) begin
					flag_reg[ch] <= 1'b1;
				end else if (match_clear[ch]) begin
					flag_reg[ch] <= 1'b0;
				end
			end
		end

		assign match_off[ch] = active_reg[ch].off;
	end

	assign match_flag     = flag_reg;
	assign match_irq      = flag_reg & ~match_off;
	assign match_time_one = active_reg[0].value;
	assign match_time_two = active_reg[1].value;

endmodule : etcmp_top

// ===== pkg/etcmp_pkg.sv
package etcmp_pkg;

	// register offsets on the serial register port
	localparam logic [5:0] MATCH_ONE_HIGH_ADDR = 6'h1B;
	localparam logic [5:0] MATCH_ONE_LOW_ADDR  = 6'h1C;
	localparam logic [5:0] MATCH_TWO_HIGH_ADDR = 6'h1D;
	localparam logic [5:0] MATCH_TWO_LOW_ADDR  = 6'h1E;

	// field layout of a high register
	localparam int OFF_BIT     = 15;
	localparam int HIGH_MSB    = 7;
	localparam int CMP_WIDTH   = 24;
	localparam int LOW_WIDTH   = 16;
	localparam int HIGH_WIDTH  = 8;

	// reset values
	localparam logic       OFF_RESET  = 1'h0;
	localparam logic [7:0] HIGH_RESET = 8'hFF;
	localparam logic [15:0] LOW_RESET = 16'hFFFF;

	// serial framing
	localparam int           HEADER_BITS = 8;
	localparam int           WORD_BITS   = 16;
	localparam int           RD_BIT      = 7;
	localparam logic [4:0]   CNT_HEADER  = 5'h08;
	localparam logic [4:0]   CNT_WORD    = 5'h18;
	localparam logic [15:0]  READ_ZERO   = 16'h0000;
	localparam logic [6:0]   RSVD_ZERO   = 7'h00;

	typedef struct packed {
		logic       off;
		logic [7:0] hi;
	} etcmp_stage_type;

	typedef struct packed {
		logic        off;
		logic [23:0] value;
	} etcmp_active_type;

	typedef enum logic [1:0] {
		ETCMP_HEAD,
		ETCMP_DATA,
		ETCMP_IDLE
	} etcmp_phase_type;

endpackage : etcmp_pkg

// ===== sim/etcmp_chk.sv
`timescale 1ns/1ps
module etcmp_chk (
	input logic        sys_clk,
	input logic        sys_rst,
	input logic [23:0] timer_value,
	input logic [1:0]  match_flag,
	input logic [1:0]  match_irq,
	input logic [1:0]  match_off,
	input logic [23:0] match_time_one,
	input logic [23:0] match_time_two
);
	logic [1:0] hit;
	assign hit = ~match_off & {timer_value == match_time_two,
		timer_value == match_time_one};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence first_hit(int i);
		hit[i] && !$past(hit[i]);
	endsequence
	reset_vals_a: assert property ($past(sys_rst) |->
		!match_off && &{match_time_one, match_time_two}) else $error("reset bad");
	irq_mask_a: assert property (
		match_irq == (match_flag & ~match_off)) else $error("irq unmasked");
	set_one_a: assert property (first_hit(0) |=> match_flag[0])
		else $error("no flag one");
	set_two_a: assert property (first_hit(1) |=> match_flag[1])
		else $error("no flag two");
	off_one_a: assert property (
		match_off[0] && !match_flag[0] |=> !match_flag[0]) else $error("flag one");
	off_two_a: assert property (
		match_off[1] && !match_flag[1] |=> !match_flag[1]) else $error("flag two");
	load_one_a: assert property ($changed(match_time_one) |=>
		$stable(match_time_one)[*8]) else $error("split load one");
	load_two_a: assert property ($changed(match_time_two) |=>
		$stable(match_time_two)[*8]) else $error("split load two");
endmodule : etcmp_chk

// ===== sim/etcmp_host.sv
`timescale 1ns/1ps
module etcmp_host (
	input  logic sys_clk,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input  logic spi_miso_out,
	input  logic spi_miso_oe_n
);
	// link clock of 125 ns: 13 system clocks low, 12 high
	localparam int LOW_CYC  = 13;
	localparam int HIGH_CYC = 12;
	initial begin
		spi_sclk <= 1'b0;
		spi_cs_n <= 1'b1;
		spi_mosi <= 1'b0;
	end
	// header then data words, single or burst, high word first
	task automatic frame(input logic [7:0] h, input logic [31:0] d,
		input int n, output logic [15:0] rd, output int drv);
		logic [39:0] sh;
		sh = {h, d};
		rd = 16'h0000;
		drv = 0;
		@(posedge sys_clk);
		spi_cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_mosi <= sh[39 - i];
			repeat (LOW_CYC) @(posedge sys_clk);
			spi_sclk <= 1'b1;
			if (i >= 8 && i < 24) begin
				rd = {rd[14:0], spi_miso_out};
				if (!spi_miso_oe_n) begin
					drv++;
				end
			end
			repeat (HIGH_CYC) @(posedge sys_clk);
			spi_sclk <= 1'b0;
		end
		repeat (LOW_CYC) @(posedge sys_clk);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
	endtask : frame
endmodule : etcmp_host

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso_out;
	logic        spi_miso_oe_n;
	int          drv;
	logic [23:0] timer_value = 24'h000000;
	logic [1:0]  match_clear = 2'h0;
	logic [1:0]  match_flag, match_irq, match_off;
	logic [23:0] match_time_one, match_time_two;
	logic [15:0] rd;
	int          miscompares = 0;
	int          compares = 0;
	always #2.5 sys_clk = ~sys_clk;
	etcmp_top DUT (.sys_clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi,
		.spi_miso_out, .spi_miso_oe_n, .timer_value, .match_clear,
		.match_flag, .match_irq, .match_off, .match_time_one, .match_time_two);
	etcmp_host host (.sys_clk, .spi_sclk, .spi_cs_n, .spi_mosi,
		.spi_miso_out, .spi_miso_oe_n);
	task automatic chk(input string s, input logic [23:0] e, g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic xfer(input logic [7:0] h, input logic [31:0] d, input int n);
		@(posedge sys_clk);
		host.frame(h, d, n, rd, drv);
		repeat (8) @(posedge sys_clk);
	endtask : xfer
	task automatic rdchk(input logic [7:0] h, input logic [15:0] e);
		xfer(h, 32'h0, 24);
		chk("read", {8'h00, e}, {8'h00, rd});
		chk("miso drive", 24'h000010, 24'(drv));
	endtask : rdchk
	task automatic t_reset;
		chk("off", 24'h0, {22'h0, match_off});
		chk("time", 24'hFFFFFF, match_time_one & match_time_two);
		rdchk(8'h9B, 16'h00FF);
		rdchk(8'h9E, 16'hFFFF);
		rdchk(8'hBF, 16'h0000);
		$display("reset test done");
	endtask : t_reset
	task automatic t_stage;
		xfer(8'h1B, 32'h80AA0000, 24);
		chk("write drive", 24'h000000, 24'(drv));
		chk("staged", 24'hFFFFFF, match_time_one);
		chk("staged off", 24'h0, {23'h0, match_off[0]});
		rdchk(8'h9B, 16'h80AA);
		xfer(8'h1C, 32'h12340000, 24);
		chk("loaded", 24'hAA1234, match_time_one);
		chk("loaded off", 24'h1, {23'h0, match_off[0]});
		$display("stage test done");
	endtask : t_stage
	task automatic t_burst;
		xfer(8'h1D, 32'h80556789, 36);
		chk("aborted", 24'hFFFFFF, match_time_two);
		xfer(8'h1D, 32'h00556789, 40);
		chk("burst", 24'h556789, match_time_two);
		chk("burst off", 24'h0, {23'h0, match_off[1]});
		$display("burst test done");
	endtask : t_burst
	task automatic t_match;
		@(posedge sys_clk);
		timer_value <= 24'hAA1234;
		repeat (3) @(posedge sys_clk);
		chk("off flag", 24'h0, {22'h0, match_flag});
		timer_value <= 24'h556789;
		repeat (3) @(posedge sys_clk);
		chk("flag", 24'h2, {22'h0, match_flag});
		chk("irq", 24'h2, {22'h0, match_irq});
		timer_value <= 24'h000000;
		match_clear <= 2'h3;
		@(posedge sys_clk);
		match_clear <= 2'h0;
		repeat (2) @(posedge sys_clk);
		chk("cleared", 24'h0, {22'h0, match_flag});
		$display("match test done");
	endtask : t_match
	task automatic t_once;
		xfer(8'h1C, 32'h34560000, 24);
		chk("lone low", 24'hAA3456, match_time_one);
		chk("lone off", 24'h1, {23'h0, match_off[0]});
		xfer(8'h1B, 32'h00120000, 24);
		chk("held off", 24'h1, {23'h0, match_off[0]});
		xfer(8'h1C, 32'h34560000, 24);
		chk("enabled", 24'h123456, match_time_one);
		chk("enabled off", 24'h0, {23'h0, match_off[0]});
		timer_value <= 24'h123456;
		repeat (3) @(posedge sys_clk);
		chk("flag one", 24'h1, {22'h0, match_flag});
		chk("irq one", 24'h1, {22'h0, match_irq});
		match_clear <= 2'h1;
		@(posedge sys_clk);
		match_clear <= 2'h0;
		repeat (3) @(posedge sys_clk);
		chk("set once", 24'h0, {22'h0, match_flag});
		timer_value <= 24'h000000;
		@(posedge sys_clk);
		timer_value <= 24'h123456;
		match_clear <= 2'h1;
		@(posedge sys_clk);
		match_clear <= 2'h0;
		repeat (2) @(posedge sys_clk);
		chk("set wins", 24'h1, {22'h0, match_flag});
		xfer(8'h1B, 32'h80123456, 40);
		chk("kept flag", 24'h1, {22'h0, match_flag});
		chk("masked irq", 24'h0, {22'h0, match_irq});
		xfer(8'h1D, 32'h80550000, 24);
		xfer(8'h1E, 32'h67890000, 24);
		chk("off two", 24'h1, {23'h0, match_off[1]});
		timer_value <= 24'h556789;
		repeat (3) @(posedge sys_clk);
		chk("off two flag", 24'h0, {23'h0, match_flag[1]});
		$display("once test done");
	endtask : t_once
	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	initial begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_reset;
		t_stage;
		t_burst;
		t_match;
		t_once;
		results;
	end
	initial begin
		#200000;
		miscompares++;
		results;
	end
endmodule : testbench
bind etcmp_top etcmp_chk chk_i (.sys_clk, .sys_rst, .timer_value, .match_flag,
	.match_irq, .match_off, .match_time_one, .match_time_two);
